// File: dv/tb_wdt_core.sv
// self-checking bench for the watchdog core, register port and events
// assumes osc toggles every 5 ref_clk: far above 31 kHz to keep runs short
`timescale 1ns/1ps

module tb_wdt_core;
    logic ref_clk = 1'b0, rst_n = 1'b0, low_freq_int_osc = 1'b0;
    logic [1:0] wd_mode_cfg = 2'h3;
    logic int_osc_divider_chg = 1'b0, wd_clear_instr = 1'b0;
    logic sleep_enter = 1'b0, sleep_exit = 1'b0, sleeping = 1'b0;
    logic osc_startup_timer = 1'b0, osc_fail = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic wd_reset_req, wd_wake_req, timeout_flag, powerdown_flag, irq;
    int   n_fail = 0, total_checks = 0, n_rst = 0, n_wk = 0;

    wdt_core u_dut (.ref_clk, .rst_n, .low_freq_int_osc, .wd_mode_cfg,
        .int_osc_divider_chg, .wd_clear_instr, .sleep_enter, .sleep_exit,
        .sleeping, .osc_startup_timer, .osc_fail, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .wd_reset_req, .wd_wake_req,
        .timeout_flag, .powerdown_flag, .irq);

    ////////////////////////////////////////////////////////////////////////
    always #5 ref_clk = ~ref_clk;
    always begin
        repeat (5) @(posedge ref_clk);
        low_freq_int_osc <= ~low_freq_int_osc;
    end
    // counted on the falling edge so reads at the rising edge never race
    always @(negedge ref_clk) begin
        if (wd_reset_req === 1'b1) n_rst++;
        if (wd_wake_req === 1'b1) n_wk++;
    end

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(reg_rdata === e, "read data");
    endtask
    // sl: enter sleep instead of a clear, then wake at the end
    task automatic run(input logic [4:0] c, input logic [1:0] m,
                       input logic sw, input logic sl, input int lo,
                       input int hi, input int er, input int ew);
        int r0;
        int w0;
        wr(4'h0, {2'h0, c, sw});
        wd_mode_cfg <= m;
        sleeping <= sl;
        if (sl) sleep_enter <= 1'b1;
        else wd_clear_instr <= 1'b1;
        @(posedge ref_clk);
        sleep_enter <= 1'b0;
        wd_clear_instr <= 1'b0;
        r0 = n_rst;
        w0 = n_wk;
        repeat (lo) @(posedge ref_clk);
        chk(n_rst == r0 && n_wk == w0, "early time-out");
        repeat (hi - lo) @(posedge ref_clk);
        chk(n_rst - r0 == er && n_wk - w0 == ew, "time-out count");
        if (er + ew > 0)
            chk(!timeout_flag && powerdown_flag === !sl, "flags");
        if (sl) begin
            sleep_exit <= 1'b1;
            sleeping <= 1'b0;
            @(posedge ref_clk);
            sleep_exit <= 1'b0;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(4'h0, 8'h16);
        rd(4'h2, 8'h00);
        rd(4'hc, 8'h0d);
        wr(4'h8, 8'h01);
        rd(4'h8, 8'h01);
        run(5'h00, 2'h3, 1'b0, 1'b0, 300, 340, 1, 0);
        chk(irq === 1'b1, "irq not raised");
        rd(4'h4, 8'h01);
        @(posedge ref_clk);
        chk(irq === 1'b0, "irq not cleared");
        run(5'h01, 2'h3, 1'b0, 1'b0, 600, 680, 1, 0);
        run(5'h13, 2'h3, 1'b0, 1'b0, 300, 340, 1, 0);
        run(5'h1f, 2'h3, 1'b0, 1'b0, 300, 340, 1, 0);
        run(5'h00, 2'h0, 1'b1, 1'b0, 700, 700, 0, 0);
        run(5'h00, 2'h1, 1'b1, 1'b0, 300, 340, 1, 0);
        run(5'h00, 2'h1, 1'b0, 1'b0, 700, 700, 0, 0);
        run(5'h00, 2'h2, 1'b0, 1'b0, 300, 340, 1, 0);
        run(5'h00, 2'h2, 1'b1, 1'b1, 700, 700, 0, 0);
        run(5'h00, 2'h3, 1'b0, 1'b1, 300, 340, 0, 1);
        run(5'h00, 2'h1, 1'b1, 1'b1, 300, 340, 0, 1);
        wr(4'h8, 8'h00);
        int_osc_divider_chg <= 1'b1;
        run(5'h00, 2'h3, 1'b0, 1'b0, 300, 340, 1, 0);
        chk(irq === 1'b0, "masked irq raised");
        osc_fail <= 1'b1;
        run(5'h00, 2'h3, 1'b0, 1'b0, 700, 700, 0, 0);
        osc_fail <= 1'b0;
        osc_startup_timer <= 1'b1;
        run(5'h00, 2'h3, 1'b0, 1'b0, 700, 700, 0, 0);
        osc_startup_timer <= 1'b0;
        repeat (3) begin
            repeat (250) @(posedge ref_clk);
            wd_clear_instr <= 1'b1;
            @(posedge ref_clk);
            wd_clear_instr <= 1'b0;
        end
        chk(timeout_flag === 1'b1, "clear did not hold off");
        // second reset in mid-run: period code must come back to default
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(4'h0, 8'h16);
        chk(timeout_flag === 1'b1 && irq === 1'b0, "reset state");
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        complete_run();
    end
endmodule

// File: dv/wdt_core_properties.sv
// concurrent checks on the watchdog core ports
// assumes a bind onto wdt_core, single ref_clk domain
`timescale 1ns/1ps

module wdt_core_properties (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // events and configuration
    input wire logic [1:0] wd_mode_cfg,
    input wire logic       wd_clear_instr,
    input wire logic       sleep_enter,
    input wire logic       sleeping,
    input wire logic       osc_startup_timer,
    input wire logic       osc_fail,
    // results
    input wire logic [7:0] reg_rdata,
    input wire logic       wd_reset_req,
    input wire logic       wd_wake_req,
    input wire logic       timeout_flag,
    input wire logic       powerdown_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    upper_zero_a:
        assert property (reg_rdata[7:6] == 2'h0)
        else $error("upper read bits not zero");
    off_quiet_a:
        assert property (wd_mode_cfg == 2'h0
                         |=> !wd_reset_req && !wd_wake_req)
        else $error("time-out while mode off");
    nslp_quiet_a:
        assert property (wd_mode_cfg == 2'h2 && sleeping |=> !wd_wake_req)
        else $error("wake in sleep with sleep-off mode");
    sleep_no_rst_a:
        assert property (sleeping |=> !wd_reset_req)
        else $error("reset request while asleep");
    awake_no_wake_a:
        assert property (!sleeping |=> !wd_wake_req)
        else $error("wake request while awake");
    clear_quiet_a:
        assert property (wd_clear_instr || osc_fail
                         |=> !wd_reset_req && !wd_wake_req)
        else $error("time-out right after clear");
    startup_hold_a:
        assert property (osc_startup_timer |=> !wd_reset_req && !wd_wake_req)
        else $error("time-out during start-up hold");
    wake_flags_a:
        assert property (wd_wake_req |-> !timeout_flag && !powerdown_flag)
        else $error("flags wrong on sleep time-out");
    rst_flag_a:
        assert property (wd_reset_req |-> !timeout_flag && powerdown_flag)
        else $error("flags wrong on awake time-out");
    restart_a:
        assert property (wd_reset_req |=> !wd_reset_req [*8])
        else $error("counter did not restart");
    sleep_entry_a:
        assert property (sleep_enter |=> timeout_flag && !powerdown_flag)
        else $error("flags wrong after sleep entry");
endmodule

bind wdt_core wdt_core_properties u_props (.ref_clk, .rst_n, .wd_mode_cfg,
    .wd_clear_instr, .sleep_enter, .sleeping, .osc_startup_timer, .osc_fail,
    .reg_rdata, .wd_reset_req, .wd_wake_req, .timeout_flag, .powerdown_flag);

// File: logic/wdt_core.sv
// watchdog timer core counting ticks of the low frequency oscillator
// assumes osc tick is an async level toggling at 31 kHz; core pulses sync
//
// Operation
// - count only low_freq_int_osc ticks
// - mode 11 active always, sleep too
// - mode 10 active awake, off asleep
// - mode 01 follows soft_wd_on bit
// - soft bit ignored otherwise; 00 off
// - period code sets 2^(5+code) ratio
// - reserved codes give 1:32 minimum
// - period code resets to 01011
// - clear on reset, instruction, osc fail
// - clear on sleep entry, resume counting
// - clear on wake, hold during startup
// - held clear while disabled
// - oscillator divider change leaves count
// - sleep timeout wakes, clears flags, no reset
// - upper two control bits read zero
// - awake timeout resets device
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module wdt_core (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // oscillator and configuration
    input  wire logic        low_freq_int_osc,
    input  wire logic [1:0]  wd_mode_cfg,
    input  wire logic        int_osc_divider_chg,
    // processor core events, same clock
    input  wire logic        wd_clear_instr,
    input  wire logic        sleep_enter,
    input  wire logic        sleep_exit,
    input  wire logic        sleeping,
    input  wire logic        osc_startup_timer,
    input  wire logic        osc_fail,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // results
    output logic             wd_reset_req,
    output logic             wd_wake_req,
    output logic             timeout_flag,
    output logic             powerdown_flag,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic                        osc_s1_ff;
    logic                        osc_s2_ff;
    logic                        osc_s3_ff;
    logic                        soft_wd_on_ff;
    logic [4:0]                  wd_period_sel_ff;
    logic [wdt_pkg::CNT_W-1:0]   cnt_ff;
    logic [wdt_pkg::CNT_W-1:0]   nxt_cnt;
    logic [1:0]                  irq_stat_ff;
    logic [1:0]                  irq_mask_ff;
    logic                        tick;
    logic                        active;
    logic                        hold_clear;
    logic                        expired;
    logic [wdt_pkg::CNT_W-1:0]   limit;
    logic [1:0]                  nxt_stat;

    ////////////////////////////////////////////////////////////////////////
    // oscillator synchroniser; the only time base
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end else begin
            osc_s1_ff <= low_freq_int_osc;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end

    assign tick = osc_s2_ff & ~osc_s3_ff;

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    always_comb begin
        case (wd_mode_cfg)
            wdt_pkg::MODE_ALWAYS:   active = 1'b1;
            wdt_pkg::MODE_NO_SLEEP: active = ~sleeping;
            wdt_pkg::MODE_SOFTWARE: active = soft_wd_on_ff;
            wdt_pkg::MODE_OFF:      active = 1'b0;
            default:                active = 1'b0;
        endcase
    end

    // limit: reserved codes fall back to the shortest period
    always_comb begin
        if (wd_period_sel_ff > wdt_pkg::PSEL_MAX_CODE) begin
            limit = wdt_pkg::CNT_W'(1) << wdt_pkg::PSEL_BASE_SHIFT;
        end else begin
            limit = wdt_pkg::CNT_W'(1)
                    << (wdt_pkg::PSEL_BASE_SHIFT + 32'(wd_period_sel_ff));
        end
    end

    // divider change is not an input to clearing at all
    assign hold_clear = ~active
                      | wd_clear_instr | osc_fail
                      | sleep_enter
                      | sleep_exit | osc_startup_timer;

    assign expired = tick && (cnt_ff == limit - 1'b1);

    ////////////////////////////////////////////////////////////////////////
    // counter; int_osc_divider_chg deliberately unused
    always_comb begin
        nxt_cnt = cnt_ff;
        if (hold_clear || expired) begin
            nxt_cnt = '0;
        end else if (tick) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time-out outcome: reset when awake, wake when asleep
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_reset_req <= 1'b0;
            wd_wake_req  <= 1'b0;
        end else begin
            wd_reset_req <= expired && !hold_clear && !sleeping;
            wd_wake_req  <= expired && !hold_clear && sleeping;
        end
    end

    // status flags: time-out clears flag, power-down flag follows sleep
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (expired && !hold_clear) begin
            timeout_flag   <= 1'b0;
            powerdown_flag <= ~sleeping;
        end else if (sleep_enter) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b0;
        end else if (wd_clear_instr) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_wd_on_ff    <= 1'b0;
            wd_period_sel_ff <= wdt_pkg::PSEL_RESET;
        end else if (reg_wr && reg_addr == wdt_pkg::ADDR_CTRL) begin
            soft_wd_on_ff    <= reg_wdata[wdt_pkg::CTRL_SOFT_ON_BIT];
            wd_period_sel_ff <= reg_wdata[wdt_pkg::CTRL_PSEL_LSB +: 5];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over clear-on-read
    always_comb begin
        nxt_stat = irq_stat_ff;
        if (reg_rd && reg_addr == wdt_pkg::ADDR_IRQ_STAT) begin
            nxt_stat = 2'h0;
        end
        if (expired && !hold_clear) begin
            nxt_stat[wdt_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
            nxt_stat[wdt_pkg::IRQ_WAKE_BIT]    =
                nxt_stat[wdt_pkg::IRQ_WAKE_BIT] | sleeping;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
            irq         <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_stat;
            if (reg_wr && reg_addr == wdt_pkg::ADDR_IRQ_MASK) begin
                irq_mask_ff <= reg_wdata[1:0];
            end
            irq <= |(nxt_stat & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                wdt_pkg::ADDR_CTRL:
                    reg_rdata <= {2'h0, wd_period_sel_ff, soft_wd_on_ff};
                wdt_pkg::ADDR_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_ff};
                wdt_pkg::ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_ff};
                wdt_pkg::ADDR_STATE:
                    reg_rdata <= {4'h0, timeout_flag, powerdown_flag,
                                  sleeping, active};
                default:                reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// File: logic/wdt_pkg.sv
// package for the watchdog timer core: register map, fields, reset values
// assumes a single 100 MHz ref_clk domain and a plain register port
package wdt_pkg;

    // register map
    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STAT   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'h8;
    localparam logic [3:0] ADDR_STATE      = 4'hc;

    // control register fields
    localparam int         CTRL_SOFT_ON_BIT = 0;
    localparam int         CTRL_PSEL_LSB    = 1;
    localparam logic [4:0] PSEL_RESET       = 5'h0b;
    localparam logic [4:0] PSEL_MAX_CODE    = 5'h12;
    localparam int         PSEL_BASE_SHIFT  = 5;

    // mode configuration encodings
    localparam logic [1:0] MODE_OFF         = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE    = 2'h1;
    localparam logic [1:0] MODE_NO_SLEEP    = 2'h2;
    localparam logic [1:0] MODE_ALWAYS      = 2'h3;

    // interrupt status bits
    localparam int         IRQ_TIMEOUT_BIT  = 0;
    localparam int         IRQ_WAKE_BIT     = 1;

    // counter width: 2^23 ticks need 24 bits
    localparam int         CNT_W            = 24;

endpackage
